// ==== logic/island_pkg.sv ====
// constants shared by the island packet sender and its helpers
package island_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int          ADDR_W        = 10;
	localparam logic [9:0]  OFF_BUF_END   = 10'h200;
	localparam logic [9:0]  OFF_CTRL      = 10'h200;
	localparam logic [9:0]  OFF_STATUS    = 10'h204;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam int          CTRL_EN_LSB   = 0;
	localparam int          CTRL_MODE_LSB = 8;
	localparam int          STAT_TYPE_LSB = 0;
	localparam int          STAT_BUSY_BIT = 3;
	localparam int          STAT_NULL_BIT = 4;
	localparam int          STAT_PEND_LSB = 8;
	localparam int          STAT_FRM_LSB  = 16;

	// ************************************************************
	// port modes and packet types
	// ************************************************************
	localparam logic [1:0] MODE_HDMI = 2'h0;
	localparam logic [1:0] MODE_DP   = 2'h1;
	localparam logic [1:0] MODE_EDP  = 2'h2;

	localparam logic [2:0] TYPE_GCP = 3'h0;
	localparam logic [2:0] TYPE_AVI = 3'h1;
	localparam logic [2:0] TYPE_SPD = 3'h2;
	localparam logic [2:0] TYPE_VS  = 3'h3;
	localparam logic [2:0] TYPE_GMP = 3'h4;
	localparam logic [2:0] TYPE_DRM = 3'h5;
	localparam logic [2:0] TYPE_VSC = 3'h6;
	localparam logic [2:0] TYPE_PPS = 3'h7;

	localparam logic [7:0] SUPPORT_HDMI = 8'h3f;
	localparam logic [7:0] SUPPORT_DP   = 8'hd0;
	localparam logic [7:0] SUPPORT_EDP  = 8'h50;

	// ************************************************************
	// buffer layouts
	// ************************************************************
	typedef enum {LAYOUT_HDMI, LAYOUT_VSC, LAYOUT_DP} layout_e;

	localparam int         NUM_TYPES     = 8;
	localparam int         BUF_DWORDS    = 9;
	localparam logic [3:0] DATA_DW_STD   = 4'h8;
	localparam logic [3:0] DATA_DW_VSC   = 4'h9;
	localparam logic [3:0] ECC_BASE_HDMI = 4'h8;
	localparam logic [3:0] ECC_BASE_VSC  = 4'h9;
	localparam logic [3:0] ECC_BASE_DP   = 4'ha;
	localparam logic [3:0] ECC_CNT_HDMI  = 4'h2;
	localparam logic [3:0] ECC_CNT_DP    = 4'h3;
	localparam logic [7:0] ECC_POLY      = 8'h07;

	localparam int PKT_W      = 32;
	localparam int FIFO_DEPTH = 4;

endpackage : island_pkg

// ==== logic/island_fifo.sv ====
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module island_fifo #(
	parameter int WIDTH = 37,
	parameter int DEPTH = island_pkg::FIFO_DEPTH
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_ce,
	input  wire logic             i_flush,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [PW:0]      count_reg;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1))
			return '0;
		return p + PW'(1);
	endfunction : ptr_inc

	assign o_ready = (count_reg != (PW+1)'(DEPTH));
	assign o_valid = (count_reg != '0);
	assign o_data  = mem_reg[rd_ptr_reg];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_ff @(posedge i_clk)
	begin
		if (i_ce && push)
			mem_reg[wr_ptr_reg] <= i_data;
	end

	// flush drops whatever is queued, used when the port goes away
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else if (i_ce)
		begin
			if (i_flush)
			begin
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
				count_reg  <= '0;
			end
			else
			begin
				if (push)
					wr_ptr_reg <= ptr_inc(wr_ptr_reg);
				if (pop)
					rd_ptr_reg <= ptr_inc(rd_ptr_reg);
				if (push && !pop)
					count_reg <= count_reg + (PW+1)'(1);
				else if (pop && !push)
					count_reg <= count_reg - (PW+1)'(1);
			end
		end
	end

endmodule : island_fifo
`default_nettype wire

// ==== logic/island_ecc.sv ====
// check bytes over header and payload bytes of one packet buffer
`timescale 1ns/1ps
`default_nettype none
module island_ecc #(
	parameter logic [7:0] POLY = island_pkg::ECC_POLY
) (
	input  wire logic [31:0]  i_header,
	input  wire logic [255:0] i_payload,
	output logic      [7:0]   o_hdr_hdmi,
	output logic      [31:0]  o_pay_hdmi,
	output logic      [31:0]  o_hdr_dp,
	output logic      [63:0]  o_pay_dp
);

	// serial division over up to seven bytes, lowest byte first
	function automatic logic [7:0] ecc8(input logic [55:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 56; i++)
		begin
			if (r[7] ^ d[i])
				r = {r[6:0], 1'b0} ^ POLY;
			else
				r = {r[6:0], 1'b0};
		end
		return r;
	endfunction : ecc8

	always_comb
	begin
		o_hdr_hdmi = ecc8({32'h0000_0000, i_header[23:0]});
		// subpacket k spans payload bytes 7k to 7k+6
		for (int k = 0; k < 4; k++)
			o_pay_hdmi[k*8 +: 8] = ecc8(i_payload[k*56 +: 56]);
		for (int k = 0; k < 4; k++)
			o_hdr_dp[k*8 +: 8] = ecc8({48'h0, i_header[k*8 +: 8]});
		for (int k = 0; k < 8; k++)
			o_pay_dp[k*8 +: 8] = ecc8({24'h00_0000, i_payload[k*32 +: 32]});
	end

endmodule : island_ecc
`default_nettype wire

// ==== logic/video_island_packet_sender.sv ====
// per-transcoder island packet buffers, check bytes and blanking sender
`timescale 1ns/1ps
`default_nettype none
module video_island_packet_sender #(
	parameter int FIFO_DEPTH = island_pkg::FIFO_DEPTH
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_ce,
	input  wire logic [9:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_port_en,
	input  wire logic        i_trans_en,
	input  wire logic        i_vsync,
	input  wire logic        i_vblank,
	output logic      [31:0] o_pkt_data,
	output logic      [2:0]  o_pkt_type,
	output logic             o_pkt_null,
	output logic             o_pkt_sop,
	output logic             o_pkt_eop,
	output logic             o_pkt_valid,
	input  wire logic        i_pkt_ready
);

	localparam int FW = island_pkg::PKT_W + 6;

	typedef enum {ST_IDLE, ST_SEND} send_state_e;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic island_pkg::layout_e layout_of(input logic [1:0] mode,
		input logic [2:0] t);
		if (mode == island_pkg::MODE_HDMI)
			return island_pkg::LAYOUT_HDMI;
		if (t == island_pkg::TYPE_VSC)
			return island_pkg::LAYOUT_VSC;
		return island_pkg::LAYOUT_DP;
	endfunction : layout_of

	function automatic logic [3:0] data_dw(input island_pkg::layout_e l);
		return (l == island_pkg::LAYOUT_VSC) ? island_pkg::DATA_DW_VSC
			: island_pkg::DATA_DW_STD;
	endfunction : data_dw

	function automatic logic [3:0] ecc_base(input island_pkg::layout_e l);
		case (l)
			island_pkg::LAYOUT_HDMI: return island_pkg::ECC_BASE_HDMI;
			island_pkg::LAYOUT_VSC:  return island_pkg::ECC_BASE_VSC;
			default:                 return island_pkg::ECC_BASE_DP;
		endcase
	endfunction : ecc_base

	function automatic logic [3:0] ecc_cnt(input island_pkg::layout_e l);
		return (l == island_pkg::LAYOUT_HDMI) ? island_pkg::ECC_CNT_HDMI
			: island_pkg::ECC_CNT_DP;
	endfunction : ecc_cnt

	function automatic logic [7:0] support_of(input logic [1:0] mode);
		case (mode)
			island_pkg::MODE_HDMI: return island_pkg::SUPPORT_HDMI;
			island_pkg::MODE_DP:   return island_pkg::SUPPORT_DP;
			island_pkg::MODE_EDP:  return island_pkg::SUPPORT_EDP;
			default:               return 8'h00;
		endcase
	endfunction : support_of

	// k-th check dword of a layout
	function automatic logic [31:0] ecc_word(input island_pkg::layout_e l,
		input logic [3:0] k, input logic [7:0] hh, input logic [31:0] ph,
		input logic [31:0] hd, input logic [63:0] pd);
		if (l == island_pkg::LAYOUT_HDMI)
		begin
			case (k)
				4'h0:    return {24'h00_0000, hh};
				4'h1:    return ph;
				default: return 32'h0000_0000;
			endcase
		end
		case (k)
			4'h0:    return hd;
			4'h1:    return pd[31:0];
			4'h2:    return pd[63:32];
			default: return 32'h0000_0000;
		endcase
	endfunction : ecc_word

	// stored dword as seen from outside; hdmi lane 3 of dword 0 is reserved
	function automatic logic [31:0] data_word(input island_pkg::layout_e l,
		input logic [3:0] d, input logic [31:0] w);
		if (l == island_pkg::LAYOUT_HDMI && d == 4'h0)
			return {8'h00, w[23:0]};
		return w;
	endfunction : data_word

	// ************************************************************
	// registers and buffers
	// ************************************************************
	logic [31:0]       buf_reg [island_pkg::NUM_TYPES][island_pkg::BUF_DWORDS];
	logic [31:0]       ctrl_reg;
	logic [31:0]       rdata_reg;
	logic [7:0]        pending_reg;
	logic              null_pend_reg;
	logic [15:0]       frame_cnt_reg;
	send_state_e       state_reg;
	logic [2:0]        tx_type_reg;
	logic              tx_null_reg;
	logic [3:0]        tx_idx_reg;
	logic [31:0]       out_data_reg;
	logic [2:0]        out_type_reg;
	logic              out_null_reg;
	logic              out_sop_reg;
	logic              out_eop_reg;
	logic              out_valid_reg;

	logic [1:0]        mode;
	logic [7:0]        eff_en;
	logic              active;
	logic              buf_sel;
	logic [2:0]        rd_type;
	logic [3:0]        rd_dw;
	island_pkg::layout_e rd_lay;
	island_pkg::layout_e tx_lay;
	logic [31:0]       rd_word;
	logic [7:0]        rd_hh;
	logic [31:0]       rd_ph;
	logic [31:0]       rd_hd;
	logic [63:0]       rd_pd;
	logic [7:0]        tx_hh;
	logic [31:0]       tx_ph;
	logic [31:0]       tx_hd;
	logic [63:0]       tx_pd;
	logic [255:0]      rd_payload;
	logic [255:0]      tx_payload;
	logic [31:0]       tx_word;
	logic [3:0]        tx_len;
	logic [2:0]        pick;
	logic              pick_any;
	logic              fifo_in_valid;
	logic              fifo_in_ready;
	logic [FW-1:0]     fifo_in_data;
	logic [FW-1:0]     fifo_out_data;
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic              flush;

	assign mode    = ctrl_reg[island_pkg::CTRL_MODE_LSB +: 2];
	assign eff_en  = ctrl_reg[island_pkg::CTRL_EN_LSB +: 8] & support_of(mode);
	assign active  = i_port_en && i_trans_en;
	assign flush   = !i_port_en;
	assign buf_sel = (i_addr < island_pkg::OFF_BUF_END);
	assign rd_type = i_addr[8:6];
	assign rd_dw   = i_addr[5:2];
	assign rd_lay  = layout_of(mode, rd_type);
	assign tx_lay  = tx_null_reg ? island_pkg::LAYOUT_HDMI : layout_of(mode, tx_type_reg);
	assign tx_len  = data_dw(tx_lay) + ecc_cnt(tx_lay);

	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			rd_payload[i*32 +: 32] = buf_reg[rd_type][i+1];
			tx_payload[i*32 +: 32] = tx_null_reg ? 32'h0000_0000 : buf_reg[tx_type_reg][i+1];
		end
	end

	// ************************************************************
	// check byte generators
	// ************************************************************
	island_ecc u_rd_ecc (
		.i_header   (data_word(rd_lay, 4'h0, buf_reg[rd_type][0])),
		.i_payload  (rd_payload),
		.o_hdr_hdmi (rd_hh),
		.o_pay_hdmi (rd_ph),
		.o_hdr_dp   (rd_hd),
		.o_pay_dp   (rd_pd)
	);

	island_ecc u_tx_ecc (
		.i_header   (tx_null_reg ? 32'h0000_0000
			: data_word(tx_lay, 4'h0, buf_reg[tx_type_reg][0])),
		.i_payload  (tx_payload),
		.o_hdr_hdmi (tx_hh),
		.o_pay_hdmi (tx_ph),
		.o_hdr_dp   (tx_hd),
		.o_pay_dp   (tx_pd)
	);

	// ************************************************************
	// register writes
	// ************************************************************
	// check dwords have no storage, so writes there fall away
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			for (int t = 0; t < island_pkg::NUM_TYPES; t++)
				for (int d = 0; d < island_pkg::BUF_DWORDS; d++)
					buf_reg[t][d] <= 32'h0000_0000;
		end
		else if (i_ce && i_wr && buf_sel && rd_dw < data_dw(rd_lay))
			buf_reg[rd_type][rd_dw] <= i_wdata;
	end

	// enable bits are left alone when the port drops
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ctrl_reg <= island_pkg::CTRL_RESET;
		else if (i_ce && i_wr && i_addr == island_pkg::OFF_CTRL)
			ctrl_reg <= {22'h00_0000, i_wdata[9:0]};
	end

	// ************************************************************
	// register reads
	// ************************************************************
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (buf_sel)
		begin
			if (rd_dw < data_dw(rd_lay))
				rd_word = data_word(rd_lay, rd_dw, buf_reg[rd_type][rd_dw]);
			else if (rd_dw >= ecc_base(rd_lay)
				&& rd_dw < ecc_base(rd_lay) + ecc_cnt(rd_lay))
				rd_word = ecc_word(rd_lay, rd_dw - ecc_base(rd_lay),
					rd_hh, rd_ph, rd_hd, rd_pd);
		end
		else if (i_addr == island_pkg::OFF_CTRL)
			rd_word = ctrl_reg;
		else if (i_addr == island_pkg::OFF_STATUS)
		begin
			rd_word[island_pkg::STAT_TYPE_LSB +: 3] = tx_type_reg;
			rd_word[island_pkg::STAT_BUSY_BIT]      = (state_reg == ST_SEND);
			rd_word[island_pkg::STAT_NULL_BIT]      = null_pend_reg;
			rd_word[island_pkg::STAT_PEND_LSB +: 8] = pending_reg;
			rd_word[island_pkg::STAT_FRM_LSB +: 16] = frame_cnt_reg;
		end
	end

	// reads have no side effects on the sender
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			rdata_reg <= 32'h0000_0000;
		else if (i_ce)
			rdata_reg <= i_rd ? rd_word : 32'h0000_0000;
	end

	// ************************************************************
	// frame scheduler
	// ************************************************************
	always_comb
	begin
		pick     = 3'h0;
		pick_any = 1'b0;
		for (int i = island_pkg::NUM_TYPES - 1; i >= 0; i--)
		begin
			if (pending_reg[i])
			begin
				pick     = 3'(i);
				pick_any = 1'b1;
			end
		end
	end

	// pending is sampled from the old enable, so a same-cycle enable waits a frame
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pending_reg   <= 8'h00;
			null_pend_reg <= 1'b0;
			frame_cnt_reg <= 16'h0000;
		end
		else if (i_ce)
		begin
			if (!active)
			begin
				pending_reg   <= 8'h00;
				null_pend_reg <= 1'b0;
			end
			else if (i_vsync)
			begin
				pending_reg   <= eff_en;
				null_pend_reg <= (mode == island_pkg::MODE_HDMI) && (eff_en == 8'h00);
				frame_cnt_reg <= frame_cnt_reg + 16'h0001;
			end
			else if (state_reg == ST_IDLE && i_vblank)
			begin
				if (pick_any)
					pending_reg[pick] <= 1'b0;
				else if (null_pend_reg)
					null_pend_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// packet sequencer
	// ************************************************************
	always_comb
	begin
		if (tx_idx_reg < data_dw(tx_lay))
			tx_word = tx_null_reg ? 32'h0000_0000
				: data_word(tx_lay, tx_idx_reg, buf_reg[tx_type_reg][tx_idx_reg]);
		else
			tx_word = ecc_word(tx_lay, tx_idx_reg - data_dw(tx_lay),
				tx_hh, tx_ph, tx_hd, tx_pd);
	end

	assign fifo_in_valid = (state_reg == ST_SEND) && i_port_en;
	assign fifo_in_data  = {tx_null_reg, tx_type_reg, tx_idx_reg == 4'h0,
		tx_idx_reg == tx_len - 4'h1, tx_word};

	// once started a packet runs to its end even if its enable is cleared
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state_reg   <= ST_IDLE;
			tx_type_reg <= island_pkg::TYPE_GCP;
			tx_null_reg <= 1'b0;
			tx_idx_reg  <= 4'h0;
		end
		else if (i_ce)
		begin
			case (state_reg)
				ST_IDLE:
				begin
					tx_idx_reg <= 4'h0;
					if (active && !i_vsync && i_vblank && (pick_any || null_pend_reg))
					begin
						state_reg   <= ST_SEND;
						tx_type_reg <= pick;
						tx_null_reg <= !pick_any;
					end
				end
				ST_SEND:
				begin
					if (!i_port_en)
						state_reg <= ST_IDLE;
					else if (fifo_in_ready)
					begin
						tx_idx_reg <= tx_idx_reg + 4'h1;
						if (tx_idx_reg == tx_len - 4'h1)
							state_reg <= ST_IDLE;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// output queue and stage
	// ************************************************************
	island_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_ce      (i_ce),
		.i_flush   (flush),
		.i_data    (fifo_in_data),
		.i_valid   (fifo_in_valid),
		.o_ready   (fifo_in_ready),
		.o_data    (fifo_out_data),
		.o_valid   (fifo_out_valid),
		.i_ready   (fifo_out_ready)
	);

	assign fifo_out_ready = !flush && (!out_valid_reg || i_pkt_ready);

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= 32'h0000_0000;
			out_type_reg  <= 3'h0;
			out_null_reg  <= 1'b0;
			out_sop_reg   <= 1'b0;
			out_eop_reg   <= 1'b0;
		end
		else if (i_ce)
		begin
			if (flush)
				out_valid_reg <= 1'b0;
			else if (fifo_out_ready)
			begin
				out_valid_reg <= fifo_out_valid;
				if (fifo_out_valid)
				begin
					out_data_reg <= fifo_out_data[31:0];
					out_eop_reg  <= fifo_out_data[32];
					out_sop_reg  <= fifo_out_data[33];
					out_type_reg <= fifo_out_data[36:34];
					out_null_reg <= fifo_out_data[37];
				end
			end
		end
	end

	assign o_rdata     = rdata_reg;
	assign o_pkt_data  = out_data_reg;
	assign o_pkt_type  = out_type_reg;
	assign o_pkt_null  = out_null_reg;
	assign o_pkt_sop   = out_sop_reg;
	assign o_pkt_eop   = out_eop_reg;
	assign o_pkt_valid = out_valid_reg;

endmodule : video_island_packet_sender
`default_nettype wire

// ==== bench/island_sender_chk.sv ====
// port assertions for the island packet sender
`timescale 1ns/1ps
`default_nettype none
module island_sender_chk (
	input wire logic        i_clk,
	input wire logic        i_sys_rst,
	input wire logic        i_ce,
	input wire logic [9:0]  i_addr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        i_port_en,
	input wire logic [31:0] o_pkt_data,
	input wire logic [2:0]  o_pkt_type,
	input wire logic        o_pkt_null,
	input wire logic        o_pkt_sop,
	input wire logic        o_pkt_eop,
	input wire logic        o_pkt_valid,
	input wire logic        i_pkt_ready
);
	// ****************************************
	// link and register relations
	// ****************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	logic run;
	logic take;
	assign run = i_ce && i_port_en;
	assign take = run && o_pkt_valid && i_pkt_ready;
	stall_hold_a: assert property (
		run && o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt_data))
		else $error("dword changed while stalled");
	port_flush_a: assert property (
		i_ce && !i_port_en |=> !o_pkt_valid) else $error("valid after port off");
	port_start_a: assert property (
		$rose(o_pkt_valid) |-> $past(i_port_en)) else $error("valid without port");
	null_zero_a: assert property (
		o_pkt_valid && o_pkt_null |-> o_pkt_data == 32'h0 && o_pkt_type == 3'h0)
		else $error("null dword not zero");
	next_sop_a: assert property (
		take && o_pkt_eop |=> !o_pkt_valid || o_pkt_sop) else $error("no sop after eop");
	mid_pkt_a: assert property (
		take && !o_pkt_eop |=> !o_pkt_valid || (!o_pkt_sop && $stable(o_pkt_type)))
		else $error("packet broken");
	rdata_idle_a: assert property (
		i_ce && !i_rd |=> o_rdata == 32'h0) else $error("read data without read");
	ctrl_high_a: assert property (
		i_ce && i_rd && i_addr == island_pkg::OFF_CTRL |=> o_rdata[31:10] == 22'h0)
		else $error("control upper bits set");
	unmapped_a: assert property (
		i_ce && i_rd && i_addr >= 10'h208 |=> o_rdata == 32'h0) else $error("unmapped read");
	cover property (take && o_pkt_eop);
	cover property (o_pkt_valid && o_pkt_null);
	cover property (o_pkt_valid && !i_pkt_ready);
endmodule : island_sender_chk
bind video_island_packet_sender island_sender_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_en(i_port_en),
	.o_pkt_data(o_pkt_data), .o_pkt_type(o_pkt_type), .o_pkt_null(o_pkt_null),
	.o_pkt_sop(o_pkt_sop), .o_pkt_eop(o_pkt_eop), .o_pkt_valid(o_pkt_valid),
	.i_pkt_ready(i_pkt_ready));
`default_nettype wire

// ==== bench/island_sink.sv ====
// link sink model taking packet dwords with stalls
`timescale 1ns/1ps
`default_nettype none
module island_sink (
	input  wire logic        i_clk,
	input  wire logic        i_clr,
	input  wire logic        i_stall,
	input  wire logic [31:0] i_data,
	input  wire logic        i_null,
	input  wire logic        i_sop,
	input  wire logic        i_valid,
	output logic             o_ready
);
	// ****************************************
	// acceptance and logging
	// ****************************************
	int          pkts = 0;
	int          words = 0;
	int          nulls = 0;
	logic [31:0] log [16];
	// stalls come from the bench, which sets slow before the first frame, so every frame meets a stalling sink
	assign o_ready = !i_stall;
	always @(posedge i_clk)
	begin
		if (i_clr)
		begin
			pkts <= 0;
			words <= 0;
			nulls <= 0;
		end
		else if (i_valid && o_ready)
		begin
			if (words < 16)
				log[words] <= i_data;
			words <= words + 1;
			pkts <= pkts + int'(i_sop);
			nulls <= nulls + int'(i_sop && i_null);
		end
	end
endmodule : island_sink
`default_nettype wire

// ==== bench/test_video_island_packet_sender.sv ====
// random and directed bench for the island packet sender
`timescale 1ns/1ps
`default_nettype none
module test_video_island_packet_sender;
	// ****************************************
	// stimulus, expectations and checks
	// ****************************************
	logic        i_clk, i_sys_rst, i_wr, i_rd, i_port_en, i_trans_en, i_vsync, i_vblank;
	logic        o_pkt_null, o_pkt_sop, o_pkt_eop, o_pkt_valid, rdy, stall, slow, clr;
	logic [9:0]  i_addr;
	logic [2:0]  o_pkt_type;
	logic [1:0]  mode;
	logic [31:0] i_wdata, o_rdata, o_pkt_data, v;
	logic [31:0] seed = 32'h8;
	logic [31:0] bufm [8][16];
	int          miscompares = 0;
	int          check_count = 0;
	int          ty;
	int          hdmi_t [4] = '{1, 4, 3, 5};
	int          npk [3] = '{6, 3, 2};
	int          nwd [3] = '{60, 34, 23};
	video_island_packet_sender dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_port_en(i_port_en), .i_trans_en(i_trans_en), .i_vsync(i_vsync), .i_vblank(i_vblank),
		.o_pkt_data(o_pkt_data), .o_pkt_type(o_pkt_type), .o_pkt_null(o_pkt_null),
		.o_pkt_sop(o_pkt_sop), .o_pkt_eop(o_pkt_eop), .o_pkt_valid(o_pkt_valid), .i_pkt_ready(rdy));
	island_sink sink (.i_clk(i_clk), .i_clr(clr), .i_stall(stall), .i_data(o_pkt_data),
		.i_null(o_pkt_null), .i_sop(o_pkt_sop), .i_valid(o_pkt_valid), .o_ready(rdy));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] crc56(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h0;
		for (int i = 0; i < 56; i++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? island_pkg::ECC_POLY : 8'h0);
		return c;
	endfunction : crc56
	function automatic logic [31:0] exp_rd(input int t, input int k);
		logic [255:0] p;
		logic [31:0]  h;
		int           b;
		int           e;
		for (int j = 1; j < 9; j++)
			p[32*(j-1)+:32] = bufm[t][j];
		h = bufm[t][0];
		b = (mode != 2'h0 && t == 6) ? 9 : 8;
		e = (t == 6) ? 9 : 10;
		exp_rd = (k < b) ? bufm[t][k] : 32'h0;
		for (int j = 0; j < 4; j++)
			if (mode == 2'h0)
			begin
				if (k == 0) exp_rd[31:24] = 8'h0;
				if (k == 8 && j == 0) exp_rd[7:0] = crc56({32'h0, h[23:0]});
				if (k == 9) exp_rd[8*j+:8] = crc56(p[56*j+:56]);
			end
			else
			begin
				if (k == e) exp_rd[8*j+:8] = crc56({48'h0, h[8*j+:8]});
				if (k > e && k < e + 3) exp_rd[8*j+:8] = crc56({24'h0, p[32*(4*(k-e-1)+j)+:32]});
			end
	endfunction : exp_rd
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		if (a == island_pkg::OFF_CTRL) mode = d[9:8];
		else if (a[5:2] < ((mode != 2'h0 && a[8:6] == 3'h6) ? 9 : 8)) bufm[a[8:6]][a[5:2]] = d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd
	// optional control write lands in the vsync cycle itself
	task automatic start_frame(input logic w, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= w;
		i_addr <= island_pkg::OFF_CTRL;
		i_wdata <= d;
		if (w) mode = d[9:8];
		{i_vsync, clr, i_vblank} <= 3'h7;
		@(posedge i_clk);
		{i_wr, i_vsync, clr} <= 3'h0;
		rd(10'h104, v);
		chk(v, exp_rd(4, 1));
	endtask : start_frame
	task automatic end_frame(input int np, input int nw);
		int q;
		q = 0;
		for (int i = 0; i < 800 && q < 16; i++)
		begin
			@(posedge i_clk);
			q = (o_pkt_valid === 1'b1) ? 0 : q + 1;
		end
		i_vblank <= 1'b0;
		if (np < 0) return;
		chk(sink.pkts, np);
		chk(sink.words, nw);
	endtask : end_frame
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	always @(posedge i_clk)
		stall <= slow && (rnd() % 3 == 0);
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// tests need under a thousand cycles; this allows seventy-five thousand
	initial
	begin
		#300000;
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		{i_sys_rst, i_wr, i_rd, i_vsync, i_vblank, slow, clr} = 7'h40;
		{i_port_en, i_trans_en, i_addr, i_wdata, mode} = {2'h3, 44'h0};
		foreach (bufm[t, k]) bufm[t][k] = 32'h0;
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(island_pkg::OFF_CTRL, v);
		chk(v, island_pkg::CTRL_RESET);
		rd(island_pkg::OFF_STATUS, v);
		chk(v, 32'h0);
		rd(10'h3fc, v);
		chk(v, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			ty = hdmi_t[i%4] + (i / 4) * 2;
			if (i == 4) wr(island_pkg::OFF_CTRL, 32'h100);
			for (int k = 0; k < 13; k++) wr(10'(ty * 64 + k * 4), rnd());
			for (int k = 0; k < 13; k++)
			begin
				rd(10'(ty * 64 + k * 4), v);
				chk(v, exp_rd(ty, k));
			end
		end
		$display("test layouts done");
		slow = 1'b1;
		for (int m = 0; m < 3; m++)
		begin
			wr(island_pkg::OFF_CTRL, {22'h0, 2'(m), 8'hff});
			start_frame(1'b0, 32'h0);
			end_frame(npk[m], nwd[m]);
		end
		wr(island_pkg::OFF_CTRL, 32'h2);
		start_frame(1'b0, 32'h0);
		end_frame(1, 10);
		for (int i = 0; i < 10; i++) chk(sink.log[i], exp_rd(1, i));
		wr(island_pkg::OFF_CTRL, 32'h100);
		start_frame(1'b1, 32'h110);
		end_frame(0, 0);
		start_frame(1'b0, 32'h0);
		end_frame(1, 11);
		$display("test frames done");
		wr(island_pkg::OFF_CTRL, 32'h2);
		start_frame(1'b0, 32'h0);
		for (int i = 0; i < 64 && sink.words < 1; i++) @(posedge i_clk);
		wr(island_pkg::OFF_CTRL, 32'h0);
		end_frame(1, 10);
		start_frame(1'b0, 32'h0);
		end_frame(1, 10);
		chk(sink.nulls, 1);
		wr(island_pkg::OFF_CTRL, 32'h2);
		start_frame(1'b0, 32'h0);
		for (int i = 0; i < 64 && sink.words < 2; i++) @(posedge i_clk);
		i_port_en <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_port_en <= 1'b1;
		end_frame(-1, 0);
		chk(32'(sink.words < 10), 32'h1);
		start_frame(1'b0, 32'h0);
		end_frame(1, 10);
		i_trans_en <= 1'b0;
		start_frame(1'b0, 32'h0);
		end_frame(0, 0);
		wr(island_pkg::OFF_CTRL, 32'h0);
		$display("test aborts done");
		tally_and_finish();
	end
endmodule : test_video_island_packet_sender
`default_nettype wire
